// >>> spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
`define SPM_A_SCTL  9'h111
`define SPM_A_CTL   9'h112
`define SPM_A_PERL  9'h113
`define SPM_A_PERM  9'h114
`define SPM_A_PERH  9'h115
`define SPM_A_RAL   9'h116
`define SPM_A_RAM   9'h117
`define SPM_A_RAH   9'h118
`define SPM_A_RBL   9'h119
`define SPM_A_RBM   9'h11a
`define SPM_A_RBH   9'h11b
`define SPM_B_SEN   0
`define SPM_B_SLEEP 1
`define SPM_B_THEN  4
`define SPM_B_PKEN  5
`define SPM_B_MGEN  6
`define SPM_B_MEN   0
`define SPM_B_MSEL  3
`define SPM_B_CPLX  7
`define SPM_SCTL_RST 8'h04
`define SPM_PER_RST  24'h00_0080
`define SPM_PER_MIN  24'h00_0080
`define SPM_THR      13'h1000
`define SPM_SMP_W  14
`define SPM_MAG_W  13
`define SPM_RES_W  20
`define SPM_PER_W  24
`define SPM_SUM_W  52
`define SPM_SH_W   92
`define SPM_ITEM_W 99
`endif

// >>> spm_pkg.sv
package spm_pkg;
`include "spm_consts.svh"
typedef enum logic [1:0] {M_IDLE = 2'b00, M_CA = 2'b01, M_CB = 2'b11, M_PUSH = 2'b10} spm_mst_t;
typedef enum logic [1:0] {C_IDLE = 2'b00, C_DIV = 2'b01, C_ROOT = 2'b11} spm_cst_t;
typedef struct packed {
   spm_cst_t                st;
   logic [5:0]              cnt;
   logic [`SPM_SUM_W-1:0]   num;
   logic [`SPM_PER_W-1:0]   rem;
   logic [`SPM_MAG_W:0]     root;
   logic                    done;
} spm_calc_t;
typedef struct packed {
   logic [1:0][`SPM_ITEM_W-1:0] mem;
   logic                        wp;
   logic                        rp;
   logic [1:0]                  cnt;
} spm_buf_t;
endpackage

// >>> spm_if.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
interface spm_if;
   logic [`SPM_ITEM_W-1:0] data;
   logic                   valid;
   logic                   ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// >>> spm_buf.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
module spm_buf import spm_pkg::*; (
   input wire logic clock,
   input wire logic resetn,
   spm_if.snk       up,
   spm_if.src       dn
);
   spm_buf_t s_r;
   spm_buf_t s_nxt;
   logic     push;
   logic     pop;

   assign up.ready = (s_r.cnt != 2'd2);
   assign dn.valid = (s_r.cnt != 2'd0);
   assign dn.data  = s_r.mem[s_r.rp];
   assign push     = up.valid & up.ready;
   assign pop      = dn.valid & dn.ready;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = up.data;
         s_nxt.wp = ~s_r.wp;
      end
      if (pop) begin
         s_nxt.rp = ~s_r.rp;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 2'd1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 2'd1;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // spm_buf

// >>> spm_calc.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
module spm_calc import spm_pkg::*; (
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic                  start,
   input  wire logic [`SPM_SUM_W-1:0] sum,
   input  wire logic [`SPM_PER_W-1:0] per,
   output logic                       done,
   output logic [`SPM_RES_W-1:0]      ms,
   output logic [`SPM_RES_W-1:0]      rms
);
   spm_calc_t             s_r;
   spm_calc_t             s_nxt;
   logic [`SPM_PER_W:0]   rsh;
   logic [`SPM_MAG_W:0]   trial;
   logic [27:0]           sq;
   logic [26:0]           q;

   // Quotient stays in the low bits of num once the divide is over
   assign q    = s_r.num[26:0];
   assign done = s_r.done;
   assign ms   = q[26:7];
   assign rms  = {6'h00, s_r.root};

   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      rsh        = {s_r.rem, s_r.num[`SPM_SUM_W-1]};
      trial      = s_r.root | (14'h0001 << s_r.cnt[3:0]);
      sq         = trial * trial;
      unique case (s_r.st)
         C_IDLE: begin
            if (start) begin
               s_nxt.num = sum;
               s_nxt.rem = '0;
               s_nxt.cnt = 6'd51;
               s_nxt.st  = C_DIV;
            end
         end
         C_DIV: begin
            // Restoring divide, one quotient bit per cycle
            if (rsh >= {1'b0, per}) begin
               s_nxt.rem = rsh[`SPM_PER_W-1:0] - per;
               s_nxt.num = {s_r.num[`SPM_SUM_W-2:0], 1'b1};
            end else begin
               s_nxt.rem = rsh[`SPM_PER_W-1:0];
               s_nxt.num = {s_r.num[`SPM_SUM_W-2:0], 1'b0};
            end
            if (s_r.cnt == 6'd0) begin
               s_nxt.st   = C_ROOT;
               s_nxt.cnt  = 6'd13;
               s_nxt.root = '0;
            end else begin
               s_nxt.cnt = s_r.cnt - 6'd1;
            end
         end
         C_ROOT: begin
            if (sq <= {1'b0, q}) begin
               s_nxt.root = trial;
            end
            if (s_r.cnt == 6'd0) begin
               s_nxt.st   = C_IDLE;
               s_nxt.done = 1'b1;
            end else begin
               s_nxt.cnt = s_r.cnt - 6'd1;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // spm_calc

// >>> spm_top.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
module spm_top import spm_pkg::*; (
   input  wire logic                  clock,
   input  wire logic                  resetn,
   input  wire logic [`SPM_SMP_W-1:0] sample_a,
   input  wire logic [`SPM_SMP_W-1:0] sample_b,
   input  wire logic [8:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [7:0]                 reg_rdata,
   output logic                       monitor_serial_clock,
   output logic                       monitor_serial_data,
   output logic                       monitor_serial_frame
);
   typedef struct packed {
      logic [7:0]              sctl;
      logic [7:0]              ctl;
      logic [`SPM_PER_W-1:0]   per;
      logic [`SPM_RES_W-1:0]   resa;
      logic [`SPM_RES_W-1:0]   resb;
      logic [7:0]              rdata;
      logic [`SPM_PER_W-1:0]   cnt;
      logic [`SPM_SUM_W-1:0]   sqa;
      logic [`SPM_SUM_W-1:0]   sqb;
      logic [`SPM_SUM_W-1:0]   sna;
      logic [`SPM_SUM_W-1:0]   snb;
      logic [`SPM_MAG_W-1:0]   pka;
      logic [`SPM_MAG_W-1:0]   pkb;
      logic [`SPM_MAG_W-1:0]   tha;
      logic [`SPM_MAG_W-1:0]   thb;
      logic [`SPM_MAG_W-1:0]   spa;
      logic [`SPM_MAG_W-1:0]   spb;
      logic [`SPM_MAG_W-1:0]   sta;
      logic [`SPM_MAG_W-1:0]   stb;
      spm_mst_t                mst;
      logic                    go;
      logic [`SPM_RES_W-1:0]   ma;
      logic [`SPM_ITEM_W-1:0]  item;
      logic [`SPM_SH_W-1:0]    sh;
      logic [6:0]              blen;
      logic                    busy;
      logic                    sclk;
      logic                    sdo;
      logic                    frm;
      logic [1:0]              dcnt;
   } spm_top_t;

   spm_top_t                s_r;
   spm_top_t                s_nxt;
   logic                    calc_done;
   logic [`SPM_RES_W-1:0]   calc_ms;
   logic [`SPM_RES_W-1:0]   calc_rms;
   logic [`SPM_RES_W-1:0]   mag_now;
   logic [`SPM_MAG_W-1:0]   mag_a;
   logic [`SPM_MAG_W-1:0]   mag_b;
   logic [25:0]             sq_a;
   logic [25:0]             sq_b;
   logic [26:0]             pw_a;
   logic [26:0]             pw_b;
   logic [`SPM_PER_W-1:0]   per_eff;
   logic                    pend;
   logic                    cplx;
   logic                    pop_rdy;
   logic                    tick;
   logic [1:0]              half;
   logic [`SPM_SH_W-1:0]    sv;
   logic [6:0]              len;

   spm_if push_if ();
   spm_if pop_if ();

   spm_buf u_buf (
      .clock  (clock),
      .resetn (resetn),
      .up     (push_if),
      .dn     (pop_if)
   );

   spm_calc u_calc (
      .clock  (clock),
      .resetn (resetn),
      .start  (s_r.go),
      .sum    ((s_r.mst == M_CA) ? s_r.sna : s_r.snb),
      .per    (per_eff),
      .done   (calc_done),
      .ms     (calc_ms),
      .rms    (calc_rms)
   );

   function automatic logic [`SPM_MAG_W-1:0] mag13(input logic [`SPM_SMP_W-1:0] x);
      logic [`SPM_SMP_W-1:0] a;
      a = x[`SPM_SMP_W-1] ? (~x + 14'h0001) : x;
      // Full negative scale would need a fourteenth bit, so it clamps
      mag13 = a[`SPM_SMP_W-1] ? 13'h1fff : a[`SPM_MAG_W-1:0];
   endfunction

   function automatic logic [`SPM_RES_W-1:0] pick(input logic [7:0] ctl,
                                                  input logic [`SPM_RES_W-1:0] mg,
                                                  input logic [`SPM_MAG_W-1:0] pk,
                                                  input logic [`SPM_MAG_W-1:0] th);
      unique case (ctl[2:1])
         2'b00:   pick = mg;
         2'b01:   pick = {7'h00, pk};
         default: pick = {7'h00, th};
      endcase
   endfunction

   assign cplx     = s_r.ctl[`SPM_B_CPLX];
   assign per_eff  = (s_r.per < `SPM_PER_MIN) ? `SPM_PER_MIN : s_r.per;
   // At or past the end, so a period cut below the running count closes now instead of wrapping
   assign pend     = (s_r.cnt >= per_eff - 24'h00_0001);
   assign mag_a    = mag13(sample_a);
   assign mag_b    = mag13(sample_b);
   assign sq_a     = mag_a * mag_a;
   assign sq_b     = mag_b * mag_b;
   assign pw_a     = cplx ? ({1'b0, sq_a} + {1'b0, sq_b}) : {1'b0, sq_a};
   assign pw_b     = cplx ? pw_a : {1'b0, sq_b};
   // Complex power is always the root; otherwise the select bit decides
   assign mag_now  = (cplx || !s_r.ctl[`SPM_B_MSEL]) ? calc_rms : calc_ms;

   assign half     = (s_r.sctl[3:2] == 2'b11) ? 2'd3 :
                     (s_r.sctl[3:2] == 2'b10) ? 2'd1 : 2'd0;
   assign tick     = (s_r.dcnt == half);
   assign pop_rdy  = tick & ~s_r.sclk & ~s_r.busy & s_r.sctl[`SPM_B_SEN];
   assign pop_if.ready  = pop_rdy;
   assign push_if.valid = (s_r.mst == M_PUSH);
   assign push_if.data  = s_r.item;

   assign reg_rdata            = s_r.rdata;
   assign monitor_serial_clock = s_r.sclk;
   assign monitor_serial_data  = s_r.sdo;
   assign monitor_serial_frame = s_r.frm;

   // Serial word: enabled groups packed back to back, then left justified
   always_comb begin
      sv  = '0;
      len = 7'd0;
      if (s_r.sctl[`SPM_B_MGEN]) begin
         sv  = {sv[51:0], s_r.ma, mag_now};
         len = len + 7'd40;
      end
      if (s_r.sctl[`SPM_B_PKEN]) begin
         sv  = {sv[65:0], s_r.spa, s_r.spb};
         len = len + 7'd26;
      end
      if (s_r.sctl[`SPM_B_THEN]) begin
         sv  = {sv[65:0], s_r.sta, s_r.stb};
         len = len + 7'd26;
      end
      sv = sv << (7'd92 - len);
   end

   always_comb begin
      s_nxt    = s_r;
      s_nxt.go = 1'b0;

      if (reg_wr) begin
         unique case (reg_addr)
            `SPM_A_SCTL: s_nxt.sctl = reg_wdata;
            `SPM_A_CTL:  s_nxt.ctl = reg_wdata;
            `SPM_A_PERL: s_nxt.per[7:0] = reg_wdata;
            `SPM_A_PERM: s_nxt.per[15:8] = reg_wdata;
            `SPM_A_PERH: s_nxt.per[23:16] = reg_wdata;
            default: ;
         endcase
      end

      if (reg_rd) begin
         unique case (reg_addr)
            `SPM_A_SCTL: s_nxt.rdata = s_r.sctl;
            `SPM_A_CTL:  s_nxt.rdata = {s_r.ctl[7], 3'h0, s_r.ctl[3:0]};
            `SPM_A_PERL: s_nxt.rdata = s_r.per[7:0];
            `SPM_A_PERM: s_nxt.rdata = s_r.per[15:8];
            `SPM_A_PERH: s_nxt.rdata = s_r.per[23:16];
            `SPM_A_RAL:  s_nxt.rdata = s_r.resa[7:0];
            `SPM_A_RAM:  s_nxt.rdata = s_r.resa[15:8];
            `SPM_A_RAH:  s_nxt.rdata = {4'h0, s_r.resa[19:16]};
            `SPM_A_RBL:  s_nxt.rdata = s_r.resb[7:0];
            `SPM_A_RBM:  s_nxt.rdata = s_r.resb[15:8];
            `SPM_A_RBH:  s_nxt.rdata = {4'h0, s_r.resb[19:16]};
            default:     s_nxt.rdata = 8'h00;
         endcase
      end

      if (!s_r.ctl[`SPM_B_MEN]) begin
         s_nxt.cnt = '0;
         s_nxt.sqa = '0;
         s_nxt.sqb = '0;
         s_nxt.pka = '0;
         s_nxt.pkb = '0;
         s_nxt.tha = '0;
         s_nxt.thb = '0;
         s_nxt.mst = M_IDLE;
      end else begin
         if (pend && s_r.mst == M_IDLE) begin
            // Close the period with this cycle's sample folded in
            s_nxt.sna = s_r.sqa + {25'h000_0000, pw_a};
            s_nxt.snb = s_r.sqb + {25'h000_0000, pw_b};
            s_nxt.spa = (mag_a > s_r.pka) ? mag_a : s_r.pka;
            s_nxt.spb = (mag_b > s_r.pkb) ? mag_b : s_r.pkb;
            s_nxt.sta = s_r.tha;
            s_nxt.stb = s_r.thb;
            if (mag_a > `SPM_THR && s_r.tha != 13'h1fff) begin
               s_nxt.sta = s_r.tha + 13'h0001;
            end
            if (mag_b > `SPM_THR && s_r.thb != 13'h1fff) begin
               s_nxt.stb = s_r.thb + 13'h0001;
            end
            s_nxt.cnt = '0;
            s_nxt.sqa = '0;
            s_nxt.sqb = '0;
            s_nxt.pka = '0;
            s_nxt.pkb = '0;
            s_nxt.tha = '0;
            s_nxt.thb = '0;
            s_nxt.mst = M_CA;
            s_nxt.go  = 1'b1;
         end else if (!pend) begin
            // A period that ends while the last one is still busy waits here
            s_nxt.cnt = s_r.cnt + 24'h00_0001;
            s_nxt.sqa = s_r.sqa + {25'h000_0000, pw_a};
            s_nxt.sqb = s_r.sqb + {25'h000_0000, pw_b};
            if (mag_a > s_r.pka) begin
               s_nxt.pka = mag_a;
            end
            if (mag_b > s_r.pkb) begin
               s_nxt.pkb = mag_b;
            end
            if (mag_a > `SPM_THR && s_r.tha != 13'h1fff) begin
               s_nxt.tha = s_r.tha + 13'h0001;
            end
            if (mag_b > `SPM_THR && s_r.thb != 13'h1fff) begin
               s_nxt.thb = s_r.thb + 13'h0001;
            end
         end

         unique case (s_r.mst)
            M_IDLE: ;
            M_CA: begin
               if (calc_done) begin
                  s_nxt.ma  = mag_now;
                  s_nxt.mst = M_CB;
                  s_nxt.go  = 1'b1;
               end
            end
            M_CB: begin
               if (calc_done) begin
                  s_nxt.resa = pick(s_r.ctl, s_r.ma, s_r.spa, s_r.sta);
                  s_nxt.resb = pick(s_r.ctl, mag_now, s_r.spb, s_r.stb);
                  s_nxt.item = {len, sv};
                  if (s_r.sctl[`SPM_B_SEN] && len != 7'd0) begin
                     s_nxt.mst = M_PUSH;
                  end else begin
                     s_nxt.mst = M_IDLE;
                  end
               end
            end
            M_PUSH: begin
               if (push_if.ready) begin
                  s_nxt.mst = M_IDLE;
               end
            end
         endcase
      end

      s_nxt.dcnt = tick ? 2'd0 : s_r.dcnt + 2'd1;
      if (tick) begin
         if (s_r.sclk) begin
            // Data moves on the falling edge so it is steady at the rise
            s_nxt.sclk = 1'b0;
            s_nxt.frm  = 1'b0;
            if (s_r.busy) begin
               if (s_r.blen == 7'd1) begin
                  s_nxt.busy = 1'b0;
                  s_nxt.sdo  = 1'b0;
               end else begin
                  s_nxt.sh   = {s_r.sh[`SPM_SH_W-2:0], 1'b0};
                  s_nxt.sdo  = s_r.sh[`SPM_SH_W-2];
                  s_nxt.blen = s_r.blen - 7'd1;
               end
            end
         end else if (s_r.busy) begin
            s_nxt.sclk = 1'b1;
         end else if (pop_rdy && pop_if.valid) begin
            s_nxt.blen = pop_if.data[`SPM_ITEM_W-1:`SPM_SH_W];
            s_nxt.sh   = pop_if.data[`SPM_SH_W-1:0];
            s_nxt.sdo  = pop_if.data[`SPM_SH_W-1];
            s_nxt.frm  = 1'b1;
            s_nxt.busy = 1'b1;
         end else begin
            s_nxt.sclk = ~(s_r.sctl[`SPM_B_SLEEP] & ~pop_if.valid);
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r      <= '0;
         s_r.sctl <= `SPM_SCTL_RST;
         s_r.per  <= `SPM_PER_RST;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // spm_top

// >>> spm_serial_rx.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
module spm_serial_rx (
   input  wire logic                 monitor_serial_clock,
   input  wire logic                 monitor_serial_data,
   input  wire logic                 monitor_serial_frame,
   output logic [`SPM_SH_W-1:0]      word,
   output logic [6:0]                bits,
   output logic [7:0]                frames
);
   initial begin
      word   = '0;
      bits   = 7'h00;
      frames = 8'h00;
   end
   // Sample on the rising edge, half a bit away from where the data moves
   always @(posedge monitor_serial_clock) begin
      if (monitor_serial_frame) begin
         word   <= {{(`SPM_SH_W-1){1'b0}}, monitor_serial_data};
         bits   <= 7'h01;
         frames <= frames + 8'h01;
      end else begin
         word <= {word[`SPM_SH_W-2:0], monitor_serial_data};
         bits <= bits + 7'h01;
      end
   end
endmodule // spm_serial_rx

// >>> spm_monitor.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
module spm_checker import spm_pkg::*; (
   input wire logic                  clock,
   input wire logic                  resetn,
   input wire logic [`SPM_SMP_W-1:0] sample_a,
   input wire logic [`SPM_SMP_W-1:0] sample_b,
   input wire logic [8:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  monitor_serial_clock,
   input wire logic                  monitor_serial_data,
   input wire logic                  monitor_serial_frame
);
   logic [7:0]  sctl_r;
   logic [7:0]  ctl_r;
   logic [7:0]  perl_r;
   logic [11:0] quiet_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sctl_r <= `SPM_SCTL_RST;
         ctl_r  <= 8'h00;
         perl_r <= 8'h80;
      end else if (reg_wr) begin
         if (reg_addr == `SPM_A_SCTL) sctl_r <= reg_wdata;
         if (reg_addr == `SPM_A_CTL) ctl_r <= reg_wdata;
         if (reg_addr == `SPM_A_PERL) perl_r <= reg_wdata;
      end
   end
   // Idle span long enough for any queued words to have drained
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) quiet_r <= 12'h000;
      else if (!sctl_r[1] || !sctl_r[0] || ctl_r[0] || monitor_serial_frame) quiet_r <= 12'h000;
      else if (quiet_r != 12'hfff) quiet_r <= quiet_r + 12'h001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   resv_top_a: assert property (
      reg_rd && (reg_addr == `SPM_A_RAH || reg_addr == `SPM_A_RBH) |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved result bits read nonzero");
   per_read_a: assert property (
      reg_rd && reg_addr == `SPM_A_PERL |=> reg_rdata == $past(perl_r))
      else $error("period low byte read back wrong");
   ctl_read_a: assert property (
      reg_rd && reg_addr == `SPM_A_CTL |=> reg_rdata == ($past(ctl_r) & 8'h8f))
      else $error("control register read back wrong");
   sleep_low_a: assert property (quiet_r >= 12'h0bb8 |-> !monitor_serial_clock)
      else $error("serial clock runs while asleep and idle");
   frame_enable_a: assert property (
      $rose(monitor_serial_frame) |-> sctl_r[0] && !monitor_serial_clock)
      else $error("word started with serial output off");
   data_edge_a: assert property (
      $changed(monitor_serial_data) |-> $fell(monitor_serial_clock) || $rose(monitor_serial_frame))
      else $error("serial data moved away from a falling clock");
   div_two_a: assert property (
      $rose(monitor_serial_clock) && !sctl_r[3] |=> !monitor_serial_clock)
      else $error("divide by two high phase wrong");
   div_four_a: assert property (
      $rose(monitor_serial_clock) && sctl_r[3:2] == 2'b10 |=> monitor_serial_clock ##1 !monitor_serial_clock)
      else $error("divide by four high phase wrong");
   div_eight_a: assert property (
      $rose(monitor_serial_clock) && sctl_r[3:2] == 2'b11 |=> monitor_serial_clock[*3] ##1 !monitor_serial_clock)
      else $error("divide by eight high phase wrong");
   cover property ($rose(monitor_serial_frame));
   cover property ($rose(monitor_serial_clock) && sctl_r[3:2] == 2'b11);
   cover property (quiet_r == 12'h0bb8);
endmodule // spm_checker
bind spm_top spm_checker chk_i (
   .clock(clock), .resetn(resetn), .sample_a(sample_a), .sample_b(sample_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .monitor_serial_clock(monitor_serial_clock),
   .monitor_serial_data(monitor_serial_data), .monitor_serial_frame(monitor_serial_frame)
);

// >>> spm_top_bench.sv
`timescale 1ns/1ns
`include "spm_consts.svh"
module spm_top_bench import spm_pkg::*; ;
   logic                  clock;
   logic                  resetn;
   logic [`SPM_SMP_W-1:0] sample_a;
   logic [`SPM_SMP_W-1:0] sample_b;
   logic [8:0]            reg_addr;
   logic [7:0]            reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [7:0]            reg_rdata;
   logic                  sclk;
   logic                  sdata;
   logic                  sframe;
   logic [`SPM_SH_W-1:0]  word;
   logic [6:0]            bits;
   logic [7:0]            frames;
   int                    failures = 0;
   int                    n_checks = 0;
   logic [8:0]  rst_addr [7] = '{9'h111, 9'h112, 9'h113, 9'h114, 9'h115, 9'h116, 9'h1ff};
   logic [7:0]  rst_val  [7] = '{8'h04, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]  mode_ctl [6] = '{8'h01, 8'h09, 8'h03, 8'h05, 8'h07, 8'h81};
   logic [19:0] mode_a   [6] = '{20'h0_1388, 20'h2_faf0, 20'h0_1388, 20'h0_0080, 20'h0_0080,
                                 20'h0_16c6};
   logic [19:0] mode_b   [6] = '{20'h0_0bb8, 20'h1_12a8, 20'h0_0bb8, 20'h0_0000, 20'h0_0000,
                                 20'h0_16c6};
   spm_top uut (
      .clock(clock), .resetn(resetn), .sample_a(sample_a), .sample_b(sample_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .monitor_serial_clock(sclk), .monitor_serial_data(sdata),
      .monitor_serial_frame(sframe)
   );
   spm_serial_rx rx (
      .monitor_serial_clock(sclk), .monitor_serial_data(sdata),
      .monitor_serial_frame(sframe), .word(word), .bits(bits), .frames(frames)
   );
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [91:0] got, input logic [91:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge clock);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clock);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(negedge clock);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clock);
      reg_rd = 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask
   task automatic rd24(input logic [8:0] a, output logic [23:0] v);
      rd(a, v[7:0]);
      rd(a + 9'h001, v[15:8]);
      rd(a + 9'h002, v[23:16]);
   endtask
   // Restart first: clearing enable drops any half-filled period of the old mode
   task automatic run_mode(input logic [7:0] c, input logic [19:0] ea, input logic [19:0] eb);
      logic [23:0] v;
      wr(`SPM_A_CTL, 8'h00);
      wr(`SPM_A_CTL, c);
      repeat (600) @(negedge clock);
      rd24(`SPM_A_RAL, v);
      chk(92'(v), 92'({4'h0, ea}), "channel a result");
      rd24(`SPM_A_RBL, v);
      chk(92'(v), 92'({4'h0, eb}), "channel b result");
   endtask
   initial begin
      repeat (40000) @(posedge clock);
      failures++;
      stop_test();
   end
   initial begin
      logic [7:0]  d;
      logic [7:0]  f0;
      logic [23:0] v;
      {resetn, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      sample_a = 14'h1388;
      sample_b = 14'h3448;
      repeat (2) @(negedge clock);
      resetn = 1'b1;
      wr(`SPM_A_RAL, 8'hff);
      for (int i = 0; i < 7; i++) begin
         rd(rst_addr[i], d);
         chk(92'(d), 92'(rst_val[i]), "reset or ignored register");
      end
      repeat (300) @(negedge clock);
      rd24(`SPM_A_RAL, v);
      chk(92'(v), 92'h0, "result with monitor off");
      wr(`SPM_A_SCTL, 8'h07);
      for (int i = 0; i < 3100; i++) begin
         @(negedge clock);
         if (i > 40) chk(92'(sclk), 92'h0, "serial clock asleep");
      end
      for (int i = 0; i < 6; i++) run_mode(mode_ctl[i], mode_a[i], mode_b[i]);
      wr(`SPM_A_PERL, 8'h05);
      run_mode(8'h05, 20'h0_0080, 20'h0_0000);
      wr(`SPM_A_PERL, 8'h00);
      wr(`SPM_A_PERM, 8'h01);
      run_mode(8'h05, 20'h0_0100, 20'h0_0000);
      wr(`SPM_A_PERL, 8'h80);
      wr(`SPM_A_PERM, 8'h00);
      wr(`SPM_A_SCTL, 8'h6a);
      wr(`SPM_A_CTL, 8'h01);
      f0 = frames;
      repeat (700) @(negedge clock);
      chk(92'(frames), 92'(f0), "frames with serial output off");
      wr(`SPM_A_SCTL, 8'h6b);
      for (int i = 0; i < 3000 && bits != 7'd66; i++) @(negedge clock);
      chk(word, 92'({20'h0_1388, 20'h0_0bb8, 13'h1388, 13'h0bb8}), "magnitude and peak word");
      wr(`SPM_A_CTL, 8'h00);
      repeat (2000) @(negedge clock);
      wr(`SPM_A_SCTL, 8'h1f);
      wr(`SPM_A_CTL, 8'h01);
      for (int i = 0; i < 4000 && bits != 7'd26; i++) @(negedge clock);
      chk(word, 92'({13'h0080, 13'h0000}), "threshold word");
      stop_test();
   end
endmodule // spm_top_bench
